/* File: rtl/spi_eeprom_defines.svh */
// spi_eeprom_defines.svh: constants of the serial memory front end
// assumes inclusion by rtl files by bare name
`ifndef SPI_EEPROM_DEFINES_SVH
`define SPI_EEPROM_DEFINES_SVH
`define OP_SET_LATCH      3'h6
`define OP_CLEAR_LATCH    3'h4
`define OP_STATUS_READ    3'h5
`define OP_STATUS_WRITE   3'h1
`define OP_ARRAY_READ     3'h3
`define OP_ARRAY_WRITE    3'h2
`define ST_BUSY           0
`define ST_LATCH          1
`define ST_GUARD_LO       2
`define ST_GUARD_HI       3
`define ST_LOCK           7
`define ST_ALL_ONES       8'hff
`define MEM_DEPTH         4096
`define PAGE_BYTES        32
`define ADDR_W            12
`define QUARTER_BASE      12'hc00
`define HALF_BASE         12'h800
`define WRITE_TIME_US     5000
`define CLK_MHZ           100
`define WRITE_CYCLES      (`WRITE_TIME_US * `CLK_MHZ)
`endif

/* File: rtl/spi_eeprom_pkg.sv */
// spi_eeprom_pkg: types shared by the serial memory front end
// assumes the defines header is compiled alongside
package spi_eeprom_pkg;
  typedef enum logic [1:0] {
    PH_OP   = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10,
    PH_DONE = 2'b11
  } phase_t;
  // one finished transfer handed from link domain to core domain
  typedef struct packed {
    logic [2:0]  op;
    logic [11:0] addr;
    logic [5:0]  count;
    logic [7:0]  status_data;
  } frame_t;
endpackage

/* File: rtl/spi_eeprom_link.sv */
// spi_eeprom_link: link-clock shift engine of the serial memory
// assumes i_sck gated by pause at the top; reset by select high
`timescale 1ns/100ps
`include "spi_eeprom_defines.svh"
module spi_eeprom_link (
  input  wire logic                   i_sck,
  input  wire logic                   i_cs_n,
  input  wire logic                   i_hold_n,
  input  wire logic                   i_si,
  input  wire logic [7:0]             i_status,
  input  wire logic                   i_busy,
  input  wire logic [7:0]             i_rd_byte,
  output logic [11:0]                 o_rd_addr,
  output logic                        o_wr_stb,
  output logic [4:0]                  o_wr_idx,
  output logic [7:0]                  o_wr_byte,
  output logic                        o_so,
  output spi_eeprom_pkg::frame_t      o_frame
);
  typedef struct packed {
    spi_eeprom_pkg::phase_t phase;
    logic [2:0]             bitc;
    logic [7:0]             sh;
    logic [15:0]            addr;
    logic                   addr_byte;
    logic [5:0]             count;
    logic                   wr_stb;
    logic [7:0]             wr_byte;
    logic [4:0]             wr_idx;
    logic [7:0]             status_data;
    logic [2:0]             op;
  } lstate_t;
  lstate_t st_ff;
  lstate_t nxt_st;
  logic    so_ff;
  logic [7:0] tx_byte;
  logic       is_read;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.wr_stb = 1'b0;
    nxt_st.sh = {st_ff.sh[6:0], i_si};
    nxt_st.bitc = st_ff.bitc + 3'h1;
    if (i_hold_n && st_ff.bitc == 3'h7)
    begin
      unique case (st_ff.phase)
        spi_eeprom_pkg::PH_OP:
        begin
          nxt_st.op = nxt_st.sh[2:0];  // bit 3 ignored
          if (i_busy && nxt_st.sh[2:0] != `OP_STATUS_READ)
          begin
            // refused frame must commit nothing, even if busy ends before select rises
            nxt_st.op    = `OP_STATUS_READ;
            nxt_st.phase = spi_eeprom_pkg::PH_DONE;
          end
          else if (nxt_st.sh[2:0] == `OP_ARRAY_READ ||
                   nxt_st.sh[2:0] == `OP_ARRAY_WRITE)
            nxt_st.phase = spi_eeprom_pkg::PH_ADDR;
          else
            nxt_st.phase = spi_eeprom_pkg::PH_DATA;
        end
        spi_eeprom_pkg::PH_ADDR:
        begin
          nxt_st.addr = {st_ff.addr[7:0], nxt_st.sh};
          nxt_st.addr_byte = 1'b1;
          if (st_ff.addr_byte)
            nxt_st.phase = spi_eeprom_pkg::PH_DATA;
        end
        spi_eeprom_pkg::PH_DATA:
        begin
          if (st_ff.op == `OP_ARRAY_WRITE)
          begin
            nxt_st.wr_stb = 1'b1;
            nxt_st.wr_byte = nxt_st.sh;
            // page roll-over keeps the row, wraps the column
            nxt_st.wr_idx = st_ff.addr[4:0];
            nxt_st.addr[4:0] = st_ff.addr[4:0] + 5'h1;
            if (st_ff.count != 6'(`PAGE_BYTES))
              nxt_st.count = st_ff.count + 6'h1;
          end
          else if (st_ff.op == `OP_ARRAY_READ)
            nxt_st.addr = st_ff.addr + 16'h1;
          else if (st_ff.op == `OP_STATUS_WRITE)
          begin
            nxt_st.status_data = nxt_st.sh;
            nxt_st.count = 6'h1;
          end
        end
        spi_eeprom_pkg::PH_DONE:
          nxt_st.phase = spi_eeprom_pkg::PH_DONE;
      endcase
    end
    if (!i_hold_n)  // state frozen
      nxt_st = st_ff;
  end

  always_ff @(posedge i_sck or posedge i_cs_n)
  begin
    if (i_cs_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign is_read = (st_ff.phase == spi_eeprom_pkg::PH_DATA);
  assign tx_byte = (st_ff.op == `OP_STATUS_READ) ? i_status : i_rd_byte;

  // falling-edge launch; mode 3 idle-high edge is harmless, select resets
  always_ff @(negedge i_sck or posedge i_cs_n)
  begin
    if (i_cs_n)
      so_ff <= 1'b0;
    else if (i_hold_n && is_read)
      so_ff <= tx_byte[3'h7 - st_ff.bitc];
  end

  assign o_so      = so_ff;
  assign o_rd_addr = st_ff.addr[11:0];
  // next-state strobe: the last byte has no later clock edge before select rises
  assign o_wr_stb  = nxt_st.wr_stb;
  assign o_wr_idx  = nxt_st.wr_idx;
  assign o_wr_byte = nxt_st.wr_byte;
  assign o_frame   = '{op: st_ff.op, addr: st_ff.addr[11:0],
                       count: st_ff.count, status_data: st_ff.status_data};
endmodule

/* File: rtl/spi_eeprom_core.sv */
// spi_eeprom_core: top of the serial memory, status, array and write timer
// assumes i_clk free running; master clock, select, data, pause are async pins
`timescale 1ns/100ps
`include "spi_eeprom_defines.svh"
module spi_eeprom_core #(
  parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_si,
  input  wire logic i_wp_n,
  input  wire logic i_hold_n,
  output logic      o_so,
  output logic      o_so_oe,
  output logic      o_busy
);
  typedef struct packed {
    logic [1:0]  wp_sync;
    logic        busy;
    logic        latch;
    logic        guard_lo;
    logic        guard_hi;
    logic        lock;
    logic [22:0] timer;
    logic [4:0]  pg_idx;
    logic [5:0]  pg_count;
    logic [11:0] pg_base;
    logic [1:0]  wsync;
    logic        wsync_d;
    logic        so_oe;
    logic        so;
    logic [1:0]  so_sync;
    logic [1:0]  oe_sync;
  } cstate_t;

  cstate_t st_ff;
  cstate_t nxt_st;
  logic [7:0] mem [0:`MEM_DEPTH-1];
  logic [7:0] page_buf [0:`PAGE_BYTES-1];
  logic [7:0] page_buf_rd;
  logic [7:0] status;
  logic [7:0] rd_byte;
  logic [11:0] rd_addr;
  logic        wr_stb;
  logic [4:0]  wr_idx;
  logic [7:0]  wr_byte;
  logic        link_so;
  logic        sck_g;
  logic        sel_n;
  logic        wtog_ff;
  spi_eeprom_pkg::frame_t frame;
  spi_eeprom_pkg::frame_t frame_ff;
  logic        commit;
  logic        wp_active;
  logic [11:0] mem_addr;

  function automatic logic guarded(input logic [11:0] a, input logic hi, input logic lo);
    unique case ({hi, lo})
      2'b00: guarded = 1'b0;
      2'b01: guarded = (a >= `QUARTER_BASE);
      2'b10: guarded = (a >= `HALF_BASE);
      2'b11: guarded = 1'b1;
    endcase
  endfunction

  // held clock freezes shifting; pause low is ignored when tied high
  assign sck_g = i_sck & i_hold_n;
  // stall selection until reset released
  assign sel_n = i_cs_n | ~i_rst_n;

  assign status = st_ff.busy ? `ST_ALL_ONES :
                  {st_ff.lock, 3'h0, st_ff.guard_hi, st_ff.guard_lo, st_ff.latch, 1'b0};

  spi_eeprom_link u_link (
    .i_sck     (sck_g),
    .i_cs_n    (sel_n),
    .i_hold_n  (i_hold_n),
    .i_si      (i_si),
    .i_status  (status),
    .i_busy    (st_ff.busy),
    .i_rd_byte (rd_byte),
    .o_rd_addr (rd_addr),
    .o_wr_stb  (wr_stb),
    .o_wr_idx  (wr_idx),
    .o_wr_byte (wr_byte),
    .o_so      (link_so),
    .o_frame   (frame)
  );

  // array read is combinational for the link: half a bit time of access
  assign rd_byte = mem[rd_addr];

  // page buffer filled on the link clock, drained on i_clk after frame end
  always_ff @(posedge sck_g)
  begin
    if (wr_stb)
      page_buf[wr_idx] <= wr_byte;
  end

  // write event toggled on select rise; the link clears its frame on that same
  // rise, so the fields are held here until the next frame ends
  always_ff @(posedge i_cs_n or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wtog_ff  <= 1'b0;
      frame_ff <= '0;
    end
    else
    begin
      wtog_ff  <= ~wtog_ff;
      frame_ff <= frame;
    end
  end

  assign commit = st_ff.wsync[1] ^ st_ff.wsync_d;
  assign wp_active = ~st_ff.wp_sync[1] & st_ff.lock;
  assign mem_addr = {st_ff.pg_base[11:5], st_ff.pg_idx};
  assign page_buf_rd = page_buf[st_ff.pg_idx];

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.wp_sync = {st_ff.wp_sync[0], i_wp_n};
    nxt_st.wsync   = {st_ff.wsync[0], wtog_ff};
    nxt_st.wsync_d = st_ff.wsync[1];
    nxt_st.so_sync = {st_ff.so_sync[0], link_so};
    nxt_st.oe_sync = {st_ff.oe_sync[0], ~sel_n & i_hold_n};
    nxt_st.so      = st_ff.so_sync[1];
    // standby and pause leave the output floating; status stays readable while busy
    nxt_st.so_oe   = st_ff.oe_sync[1];
    if (st_ff.busy)
    begin
      if (st_ff.pg_count != 6'h0)
      begin
        nxt_st.pg_idx   = st_ff.pg_idx + 5'h1;
        nxt_st.pg_count = st_ff.pg_count - 6'h1;
      end
      if (st_ff.timer == 23'h0)
        nxt_st.busy = 1'b0;
      else
        nxt_st.timer = st_ff.timer - 23'h1;
    end
    else if (commit && frame_ff.count != 6'h0 && !frame_ff.op[2])
    begin
      if (frame_ff.op == `OP_STATUS_WRITE && st_ff.latch)
      begin
        nxt_st.latch = 1'b0;
        if (!wp_active)
        begin
          nxt_st.guard_lo = frame_ff.status_data[`ST_GUARD_LO];
          nxt_st.guard_hi = frame_ff.status_data[`ST_GUARD_HI];
          nxt_st.lock     = frame_ff.status_data[`ST_LOCK];
        end
        nxt_st.busy  = 1'b1;
        nxt_st.timer = 23'(WRITE_CYCLES - 1);
      end
      else if (frame_ff.op == `OP_ARRAY_WRITE && st_ff.latch)
      begin
        nxt_st.latch    = 1'b0;
        // only the row bits are used; the column wrapped inside the page
        nxt_st.pg_base  = frame_ff.addr;
        nxt_st.pg_idx   = frame_ff.addr[4:0] - 5'(frame_ff.count);
        nxt_st.pg_count = frame_ff.count;
        nxt_st.busy     = 1'b1;
        nxt_st.timer    = 23'(WRITE_CYCLES - 1);
      end
    end
    else if (commit && frame_ff.op == `OP_SET_LATCH && frame_ff.count == 6'h0)
      nxt_st.latch = 1'b1;
    else if (commit && frame_ff.op == `OP_CLEAR_LATCH)
      nxt_st.latch = 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // array programmed one byte per cycle, guarded ranges skipped
  always_ff @(posedge i_clk)
  begin
    if (st_ff.busy && st_ff.pg_count != 6'h0 &&
        !guarded(mem_addr, st_ff.guard_hi, st_ff.guard_lo))
      mem[mem_addr] <= page_buf_rd;
  end

  assign o_so    = st_ff.so;
  assign o_so_oe = st_ff.so_oe;
  assign o_busy  = st_ff.busy;
endmodule

/* File: test/spi_eeprom_checker.sv */
// spi_eeprom_checker: port assertions of the serial memory core
// assumes a bind onto spi_eeprom_core
`timescale 1ns/100ps
module spi_eeprom_checker #(
  parameter int unsigned WRITE_CYCLES = 50
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_wp_n,
  input wire logic i_hold_n,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_busy
);
  logic [31:0] busy_cnt_ff;
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      busy_cnt_ff <= 32'h0;
    else
      busy_cnt_ff <= o_busy ? busy_cnt_ff + 32'h1 : 32'h0;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence deselected;
    i_cs_n [*4];
  endsequence
  sequence selected_idle;
    (!i_cs_n && i_hold_n && !o_busy) [*6];
  endsequence
  sequence selected_busy;
    (!i_cs_n && i_hold_n && o_busy) [*6];
  endsequence
  sequence paused;
    !i_hold_n [*5];
  endsequence
  reset_quiet_a: assert property ($rose(i_rst_n) |-> !o_busy && !o_so_oe) else $error("reset out");
  standby_off_a: assert property (deselected |-> !o_so_oe) else $error("oe deselected");
  deselect_fast_a: assert property ($rose(i_cs_n) |-> ##[1:5] !o_so_oe) else $error("oe late");
  select_drive_a: assert property (selected_idle |-> o_so_oe) else $error("oe missing");
  drive_cause_a: assert property ($rose(o_so_oe) |-> !i_cs_n) else $error("oe no select");
  busy_cause_a: assert property ($rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2)) else $error("busy");
  busy_steady_a: assert property ($rose(o_busy) |-> o_busy [*8]) else $error("busy short");
  write_bound_a: assert property (busy_cnt_ff <= WRITE_CYCLES + 4) else $error("busy long");
  pause_still_a: assert property (paused |-> $stable(o_so)) else $error("so in pause");
  busy_drive_a: assert property (selected_busy |-> o_so_oe) else $error("oe off busy");
endmodule
bind spi_eeprom_core spi_eeprom_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si),
  .i_wp_n(i_wp_n), .i_hold_n(i_hold_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_busy(o_busy)
);

/* File: test/spi_master_model.sv */
// spi_master_model: master on the far side of the serial memory
// assumes the bench fills tx, reads rx; steps on core clock edges
`timescale 1ns/100ps
module spi_master_model (
  input  wire logic i_clk,
  input  wire logic i_so,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  output logic      o_hold_n
);
  logic [7:0] tx [0:7];
  logic [7:0] rx [0:7];
  logic       cpol = 1'b0;
  int         pause_at = -1;
  initial {o_sck, o_cs_n, o_si, o_hold_n} = 4'b0111;
  task automatic tick(int n);
    repeat (n) @(posedge i_clk);
  endtask
  // slow clock: read bits reach the pin some 30 ns after the falling edge
  task automatic frame(int n);
    o_sck  <= cpol;
    tick(8);
    o_cs_n <= 1'b0;
    tick(8);
    for (int i = 0; i < n * 8; i++)
    begin
      o_sck <= 1'b0;
      o_si  <= tx[i / 8][7 - i % 8];
      tick(8);
      if (i == pause_at)
      begin
        o_hold_n <= 1'b0;
        o_si     <= ~o_si;
        tick(8);
        o_sck    <= 1'b1;
        tick(8);
        o_sck    <= 1'b0;
        tick(8);
        o_hold_n <= 1'b1;
        o_si     <= tx[i / 8][7 - i % 8];
        tick(8);
      end
      rx[i / 8][7 - i % 8] = i_so;
      o_sck <= 1'b1;
      tick(8);
    end
    o_sck  <= cpol;
    o_si   <= ~o_si;
    tick(8);
    o_cs_n <= 1'b1;
    tick(8);
  endtask
endmodule

/* File: test/spi_eeprom_serial_front_end_test.sv */
// spi_eeprom_serial_front_end_test: self-checking bench of the serial memory
// assumes spi_master_model on the far side
`timescale 1ns/100ps
module spi_eeprom_serial_front_end_test;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_wp_n = 1'b1;
  logic        sck, cs_n, si, hold_n, so, so_oe, busy;
  logic [7:0]  stx = 8'h00;
  logic [7:0]  mem [0:4095];
  logic [11:0] ga [3] = '{12'h7fe, 12'hbfe, 12'hc00};
  int          err_count = 0;
  int          n_checks = 0;
  int          seed = 32'h93c6;
  initial
    forever #5 i_clk = ~i_clk;
  // released output floats to its pull-up level
  spi_master_model m (.i_clk(i_clk), .i_so(so_oe ? so : 1'b1), .o_sck(sck), .o_cs_n(cs_n),
    .o_si(si), .o_hold_n(hold_n));
  spi_eeprom_core #(.WRITE_CYCLES(400)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sck(sck),
    .i_cs_n(cs_n), .i_si(si), .i_wp_n(i_wp_n), .i_hold_n(hold_n), .o_so(so),
    .o_so_oe(so_oe), .o_busy(busy));
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic op(logic [7:0] c, int n);
    m.tx[0] = c;
    m.frame(n);
  endtask
  task automatic st_chk(string nm, logic [7:0] e);
    op(8'h05, 2);
    chk(nm, e, m.rx[1] & 8'h8f);
  endtask
  task automatic idle;
    repeat (2000)
      if (busy !== 1'b0)
        @(posedge i_clk);
    chk("busy", 8'h0, {7'h0, busy});
    if (busy !== 1'b0)
      complete_run;
  endtask
  function automatic logic prot(logic [11:0] ad);
    return stx[3:2] == 2'h3 || (stx[3] && ad >= 12'h800) || (stx[2] && ad >= 12'hc00);
  endfunction
  task automatic wr_st(logic [7:0] v);
    op(8'h06, 1);
    m.tx[1] = v;
    op(8'h01, 2);
    idle;
    if (i_wp_n || !stx[7])
      stx = v & 8'h8c;
    st_chk("status", stx);
  endtask
  task automatic wr(logic [11:0] a, int n, logic en);
    logic [11:0] b;
    if (en)
      op(8'h06, 1);
    m.tx[1] = {4'($random(seed)), a[11:8]};
    m.tx[2] = a[7:0];
    for (int i = 0; i < n; i++)
    begin
      b = {a[11:5], a[4:0] + 5'(i)};
      m.tx[3 + i] = 8'($random(seed));
      if (en && !prot(b))
        mem[b] = m.tx[3 + i];
    end
    op(8'h02, n + 3);
    op(8'h05, 2);
    if (en && !prot(a))
      chk("busy status", 8'hff, m.rx[1]);
    idle;
    st_chk("latch", stx);
  endtask
  task automatic rd(logic [11:0] a, int p);
    m.tx[1] = {4'h0, a[11:8]};
    m.tx[2] = a[7:0];
    m.pause_at = p;
    op(8'h03, 5);
    m.pause_at = -1;
    chk("read 0", mem[a], m.rx[3]);
    chk("read 1", mem[a + 12'h1], m.rx[4]);
  endtask
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    for (int md = 0; md < 2; md++)
    begin
      m.cpol = md[0];
      st_chk("idle", 8'h00);
      op({4'h0, md[0], 3'h6}, 1);
      st_chk("set", 8'h02);
      op({4'h0, md[0], 3'h4}, 1);
      st_chk("clear", 8'h00);
      $display("mode test done");
    end
    wr(12'h3de, 4, 1'b1);
    wr(12'h3c0, 1, 1'b0);
    rd(12'h3de, 12);
    rd(12'h3c0, 28);
    $display("page test done");
    for (int g = 0; g < 4; g++)
    begin
      wr_st(8'(g << 2));
      foreach (ga[j])
        wr(ga[j], 2, 1'b1);
      foreach (ga[j])
        rd(ga[j], -1);
    end
    $display("guard test done");
    i_wp_n <= 1'b0;
    wr_st(8'h8c);
    wr_st(8'h00);
    i_wp_n <= 1'b1;
    wr_st(8'h00);
    $display("lock test done");
    complete_run;
  end
endmodule
